// ### src/phy_mode_ctrl.sv
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`include "mode_ctrl_defines.svh"

// Notes on behaviour
// RQ1: at 10M, save bit gates 100M modules
// RQ2: at 100M, save bit gates 10M modules
// RQ3: negotiation enable from pin or register
// RQ4: negotiation picks best common mode
// RQ5: no loopback in 10M full duplex
// RQ6: no SQE test in 10M full duplex
// RQ7: full duplex: CRS receive only, COL off
// RQ8: 100M enables coding and scrambling path
// RQ9: half duplex: CRS tx or rx, COL overlap
// RQ10: source pin low hardware, high software
// RQ11: gating follows the resolved operating mode
module phy_mode_ctrl (
   // clock and reset
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   // axi4-lite write channels
   input  wire logic [`ADDR_W-1:0]      awaddr,
   input  wire logic                    awvalid,
   output logic                         awready,
   input  wire logic [31:0]             wdata,
   input  wire logic [3:0]              wstrb,
   input  wire logic                    wvalid,
   output logic                         wready,
   output mode_ctrl_pkg::axi_resp_t     bresp,
   output logic                         bvalid,
   input  wire logic                    bready,
   // axi4-lite read channels
   input  wire logic [`ADDR_W-1:0]      araddr,
   input  wire logic                    arvalid,
   output logic                         arready,
   output logic [31:0]                  rdata,
   output mode_ctrl_pkg::axi_resp_t     rresp,
   output logic                         rvalid,
   input  wire logic                    rready,
   // configuration pins
   input  wire logic                    config_source_select_pin,
   input  wire logic                    autoneg_select_pin,
   input  wire logic                    speed_select_pin,
   input  wire logic                    duplex_select_pin,
   // negotiation engine and line activity
   input  wire logic                    an_done,
   input  wire logic [`ABIL_W-1:0]      partner_ability,
   input  wire logic                    tx_active,
   input  wire logic                    rx_active,
   // mode and module enables
   output logic                         speed100,
   output logic                         full_duplex,
   output logic                         pwr_en_100,
   output logic                         pwr_en_10,
   output logic                         pcs100_en,
   output logic                         loopback_en,
   output logic                         sqe_test_en,
   // mii carrier and collision
   output logic                         crs,
   output logic                         col
);
   import mode_ctrl_pkg::*;

   mode_state_t st_reg;
   mode_state_t st_next;
   logic        cfg_sw_s;
   logic        autoneg_select_pin_s;
   logic        spd_pin_s;
   logic        dup_pin_s;
   logic        an_sel_w;
   logic [`ABIL_W-1:0] common_w;

   // pin synchronisers
   sync2 u_sync_cfg (.aclk(aclk), .aresetn(aresetn),
                     .din(config_source_select_pin), .dout(cfg_sw_s));
   sync2 u_sync_an  (.aclk(aclk), .aresetn(aresetn),
                     .din(autoneg_select_pin), .dout(autoneg_select_pin_s));
   sync2 u_sync_spd (.aclk(aclk), .aresetn(aresetn),
                     .din(speed_select_pin), .dout(spd_pin_s));
   sync2 u_sync_dup (.aclk(aclk), .aresetn(aresetn),
                     .din(duplex_select_pin), .dout(dup_pin_s));

   // negotiation enable source and shared abilities
   assign an_sel_w = cfg_sw_s ? st_reg.ctrl_an : autoneg_select_pin_s; // RQ3 RQ10
   assign common_w = st_reg.abil & partner_ability;

   // next state
   always_comb begin
      st_next = st_reg;
      // write address and data, taken in either order
      if (awvalid && st_reg.awrdy) begin
         st_next.awrdy = 1'b0;
         st_next.waddr = awaddr;
      end
      if (wvalid && st_reg.wrdy) begin
         st_next.wrdy  = 1'b0;
         st_next.wdata = wdata[15:0];
         st_next.wstrb = wstrb[1:0];
      end
      // register write once both halves are held
      if (!st_reg.awrdy && !st_reg.wrdy && !st_reg.bvalid) begin
         st_next.bvalid = 1'b1;
         st_next.bresp  = `RESP_OKAY;
         if (st_reg.waddr == `OFS_CTRL) begin
            if (st_reg.wstrb[1]) begin
               st_next.ctrl_an  = st_reg.wdata[`CTRL_AN_BIT];
               st_next.ctrl_spd = st_reg.wdata[`CTRL_SPD_BIT];
               st_next.ctrl_fdx = st_reg.wdata[`CTRL_FDX_BIT];
            end
         end else if (st_reg.waddr == `OFS_PWR_SAVE) begin
            if (st_reg.wstrb[0]) begin
               st_next.save100 = st_reg.wdata[`SAVE100_BIT];
               st_next.save10  = st_reg.wdata[`SAVE10_BIT];
            end
         end else if (st_reg.waddr == `OFS_ABILITY) begin
            if (st_reg.wstrb[0]) begin
               st_next.abil = st_reg.wdata[`ABIL_W-1:0];
            end
         end else if (st_reg.waddr != `OFS_STATUS) begin
            st_next.bresp = `RESP_DECERR;
         end
      end
      if (st_reg.bvalid && bready) begin
         st_next.bvalid = 1'b0;
         st_next.awrdy  = 1'b1;
         st_next.wrdy   = 1'b1;
      end
      // read address decode
      if (arvalid && st_reg.arrdy) begin
         st_next.arrdy  = 1'b0;
         st_next.rvalid = 1'b1;
         st_next.rdata  = 32'h0;
         st_next.rresp  = `RESP_OKAY;
         if (araddr == `OFS_CTRL) begin
            st_next.rdata[`CTRL_AN_BIT]  = st_reg.ctrl_an;
            st_next.rdata[`CTRL_SPD_BIT] = st_reg.ctrl_spd;
            st_next.rdata[`CTRL_FDX_BIT] = st_reg.ctrl_fdx;
         end else if (araddr == `OFS_PWR_SAVE) begin
            st_next.rdata[`SAVE100_BIT] = st_reg.save100;
            st_next.rdata[`SAVE10_BIT]  = st_reg.save10;
         end else if (araddr == `OFS_STATUS) begin
            st_next.rdata[`ST_SPD_BIT]    = st_reg.spd100;
            st_next.rdata[`ST_FDX_BIT]    = st_reg.fdx;
            st_next.rdata[`ST_AN_BIT]     = st_reg.an_en;
            st_next.rdata[`ST_CFG_BIT]    = cfg_sw_s;
            st_next.rdata[`ST_PWR100_BIT] = st_reg.pwr100;
            st_next.rdata[`ST_PWR10_BIT]  = st_reg.pwr10;
            st_next.rdata[`ST_DONE_BIT]   = an_done;
         end else if (araddr == `OFS_ABILITY) begin
            st_next.rdata[`ABIL_W-1:0] = st_reg.abil;
         end else begin
            st_next.rresp = `RESP_DECERR;
         end
      end
      if (st_reg.rvalid && rready) begin
         st_next.rvalid = 1'b0;
         st_next.arrdy  = 1'b1;
      end
      // resolved operating mode
      st_next.an_en = an_sel_w; // RQ3
      if (st_reg.an_en) begin
         // best common mode, held until negotiation completes
         if (an_done) begin
            if (common_w[`ABIL_100FD]) begin // RQ4
               st_next.spd100 = 1'b1;
               st_next.fdx    = 1'b1;
            end else if (common_w[`ABIL_100HD]) begin
               st_next.spd100 = 1'b1;
               st_next.fdx    = 1'b0;
            end else if (common_w[`ABIL_10FD]) begin
               st_next.spd100 = 1'b0;
               st_next.fdx    = 1'b1;
            end else begin
               st_next.spd100 = 1'b0;
               st_next.fdx    = 1'b0;
            end
         end
      end else begin
         // manual mode from pins or register
         st_next.spd100 = cfg_sw_s ? st_reg.ctrl_spd : spd_pin_s; // RQ10
         st_next.fdx    = cfg_sw_s ? st_reg.ctrl_fdx : dup_pin_s; // RQ10
      end
      // module gating from the resolved mode
      st_next.pwr100 = st_reg.spd100 || !st_reg.save100; // RQ1 RQ11
      st_next.pwr10  = !st_reg.spd100 || !st_reg.save10; // RQ2
      st_next.pcs100 = st_reg.spd100; // RQ8
      st_next.lpbk   = !st_reg.spd100 && !st_reg.fdx; // RQ5
      st_next.sqe    = !st_reg.spd100 && !st_reg.fdx; // RQ6
      // carrier sense and collision
      if (st_reg.fdx) begin
         st_next.crs = rx_active; // RQ7
         st_next.col = 1'b0;
      end else begin
         st_next.crs = rx_active || tx_active; // RQ9
         st_next.col = rx_active && tx_active;
      end
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg          <= '0;
         st_reg.awrdy    <= 1'b1;
         st_reg.wrdy     <= 1'b1;
         st_reg.arrdy    <= 1'b1;
         st_reg.ctrl_an  <= `CTRL_AN_RST;
         st_reg.ctrl_spd <= `CTRL_SPD_RST;
         st_reg.ctrl_fdx <= `CTRL_FDX_RST;
         st_reg.save100  <= `SAVE_RST;
         st_reg.save10   <= `SAVE_RST;
         st_reg.abil     <= `ABIL_RST;
         st_reg.pwr100   <= 1'b1;
         st_reg.pwr10    <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state register
   assign awready     = st_reg.awrdy;
   assign wready      = st_reg.wrdy;
   assign bvalid      = st_reg.bvalid;
   assign bresp       = st_reg.bresp;
   assign arready     = st_reg.arrdy;
   assign rvalid      = st_reg.rvalid;
   assign rdata       = st_reg.rdata;
   assign rresp       = st_reg.rresp;
   assign speed100    = st_reg.spd100;
   assign full_duplex = st_reg.fdx;
   assign pwr_en_100  = st_reg.pwr100;
   assign pwr_en_10   = st_reg.pwr10;
   assign pcs100_en   = st_reg.pcs100;
   assign loopback_en = st_reg.lpbk;
   assign sqe_test_en = st_reg.sqe;
   assign crs         = st_reg.crs;
   assign col         = st_reg.col;

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_both_active;
      tx_active && rx_active;
   endsequence

   property p_save100;
      !speed100 && st_reg.save100 |=> !pwr_en_100;
   endproperty
   a_save100: assert property (p_save100) // RQ1
      else $error("100M modules left on at 10M");

   property p_save10;
      speed100 && !st_reg.save10 |=> pwr_en_10;
   endproperty
   a_save10: assert property (p_save10) // RQ2
      else $error("10M modules off with save bit clear");

   property p_an_src;
      1'b1 |=> st_reg.an_en == $past(an_sel_w);
   endproperty
   a_an_src: assert property (p_an_src) // RQ3
      else $error("negotiation enable from wrong source");

   property p_best;
      st_reg.an_en && an_done && common_w[`ABIL_100FD]
         |=> speed100 && full_duplex;
   endproperty
   a_best: assert property (p_best) // RQ4
      else $error("best common mode not chosen");

   property p_no_loop;
      !speed100 && full_duplex |=> !loopback_en && !sqe_test_en;
   endproperty
   a_no_loop: assert property (p_no_loop) // RQ5 RQ6
      else $error("loopback or sqe in 10M full duplex");

   property p_fdx_crs;
      full_duplex |=> crs == $past(rx_active) && !col;
   endproperty
   a_fdx_crs: assert property (p_fdx_crs) // RQ7
      else $error("full duplex carrier or collision wrong");

   property p_hdx_col;
      (!full_duplex) and s_both_active |=> col && crs;
   endproperty
   a_hdx_col: assert property (p_hdx_col) // RQ9
      else $error("half duplex collision missed");

   property p_hw_mode;
      !cfg_sw_s && !autoneg_select_pin_s ##1 !st_reg.an_en && !cfg_sw_s
         |=> speed100 == $past(spd_pin_s);
   endproperty
   a_hw_mode: assert property (p_hw_mode) // RQ10
      else $error("hardware mode speed not from pin");

   property p_pcs;
      1'b1 |=> pcs100_en == $past(speed100);
   endproperty
   a_pcs: assert property (p_pcs) // RQ8
      else $error("100M coding path not following speed");

endmodule : phy_mode_ctrl

// ### src/mode_ctrl_defines.svh
`ifndef MODE_CTRL_DEFINES_SVH
`define MODE_CTRL_DEFINES_SVH

// register byte addresses
`define ADDR_W          8
`define OFS_CTRL        8'h00
`define OFS_PWR_SAVE    8'h04
`define OFS_STATUS      8'h08
`define OFS_ABILITY     8'h0c

// control register fields
`define CTRL_FDX_BIT    8
`define CTRL_AN_BIT     12
`define CTRL_SPD_BIT    13
`define CTRL_AN_RST     1'b1
`define CTRL_SPD_RST    1'b1
`define CTRL_FDX_RST    1'b1

// power save register fields
`define SAVE100_BIT     0
`define SAVE10_BIT      1
`define SAVE_RST        1'b0

// ability bits: 3 100 full, 2 100 half, 1 10 full, 0 10 half
`define ABIL_W          4
`define ABIL_RST        4'hf
`define ABIL_100FD      3
`define ABIL_100HD      2
`define ABIL_10FD       1

// status register fields
`define ST_SPD_BIT      0
`define ST_FDX_BIT      1
`define ST_AN_BIT       2
`define ST_CFG_BIT      3
`define ST_PWR100_BIT   4
`define ST_PWR10_BIT    5
`define ST_DONE_BIT     6

// bus responses
`define RESP_OKAY       2'h0
`define RESP_DECERR     2'h3

`endif

// ### src/mode_ctrl_pkg.sv
`include "mode_ctrl_defines.svh"

package mode_ctrl_pkg;

   typedef logic [1:0] axi_resp_t;

   typedef struct packed {
      logic                  awrdy;
      logic                  wrdy;
      logic                  bvalid;
      logic                  arrdy;
      logic                  rvalid;
      logic [31:0]           rdata;
      axi_resp_t             rresp;
      axi_resp_t             bresp;
      logic [`ADDR_W-1:0]    waddr;
      logic [15:0]           wdata;
      logic [1:0]            wstrb;
      logic                  ctrl_an;
      logic                  ctrl_spd;
      logic                  ctrl_fdx;
      logic                  save100;
      logic                  save10;
      logic [`ABIL_W-1:0]    abil;
      logic                  an_en;
      logic                  spd100;
      logic                  fdx;
      logic                  pwr100;
      logic                  pwr10;
      logic                  pcs100;
      logic                  lpbk;
      logic                  sqe;
      logic                  crs;
      logic                  col;
   } mode_state_t;

endpackage : mode_ctrl_pkg

// ### src/sync2.sv
`timescale 1ns/100ps

// two flop synchroniser for one pin
module sync2 (
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // pin and synchronised level
   input  wire logic din,
   output logic      dout
);

   logic meta_reg;

   // first flop feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= 1'b0;
         dout     <= 1'b0;
      end else begin
         meta_reg <= din;
         dout     <= meta_reg;
      end
   end

endmodule : sync2

// ### verification/mac_partner.sv
`timescale 1ns/100ps

// mac side: holds its transmit enable for one frame, idle between frames
module mac_partner (
   // clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // frame request and transmit activity
   input  wire logic       start,
   input  wire logic [7:0] frame_len,
   output logic            tx_active
);
   logic [7:0] left_reg;

   // count the frame down, one nibble a cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) left_reg <= 8'h00;
      else if (start) left_reg <= frame_len;
      else if (left_reg != 8'h00) left_reg <= left_reg - 8'h01;
   end

   assign tx_active = (left_reg != 8'h00);
endmodule : mac_partner

// ### verification/phy_mode_power_duplex_control_bench.sv
`timescale 1ns/100ps
`include "mode_ctrl_defines.svh"

module phy_mode_power_duplex_control_bench;
   import mode_ctrl_pkg::*;
   logic aclk = 0, aresetn = 0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, frame_len = 8'h1e;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0, partner_ability = 4'h0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic cfg = 1, an_pin = 0, spd_pin = 0, dup_pin = 0, an_done = 0;
   logic rx_active = 0, start = 0, tx_active;
   logic awready, wready, bvalid, arready, rvalid;
   axi_resp_t bresp, rresp, resp;
   logic speed100, full_duplex, pwr_en_100, pwr_en_10, pcs100_en;
   logic loopback_en, sqe_test_en, crs, col;
   logic [31:0] rd;
   int n_fail = 0, checks = 0, cyc = 0;

   always #2.5 aclk = ~aclk;

   phy_mode_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .config_source_select_pin(cfg),
      .autoneg_select_pin(an_pin), .speed_select_pin(spd_pin),
      .duplex_select_pin(dup_pin), .an_done(an_done),
      .partner_ability(partner_ability), .tx_active(tx_active),
      .rx_active(rx_active), .speed100(speed100),
      .full_duplex(full_duplex), .pwr_en_100(pwr_en_100),
      .pwr_en_10(pwr_en_10), .pcs100_en(pcs100_en),
      .loopback_en(loopback_en), .sqe_test_en(sqe_test_en), .crs(crs),
      .col(col));

   mac_partner mac_u (.aclk(aclk), .aresetn(aresetn), .start(start),
      .frame_len(frame_len), .tx_active(tx_active));

   task test_done;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done

   // cut a hang short
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_fail++;
         test_done;
      end
   end

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task settle;
      repeat (6) @(posedge aclk);
   endtask : settle

   // axi4-lite write, each channel released when taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a; wdata <= d; wstrb <= 4'hf;
      awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
         if (bvalid && bready) begin
            bready <= 0;
            resp = bresp;
         end
      end while (awvalid || wvalid || bready);
   endtask : wr

   task rd_reg(input logic [7:0] a);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 0;
         if (rvalid && rready) begin
            rready <= 0;
            rd = rdata;
            resp = rresp;
         end
      end while (arvalid || rready);
   endtask : rd_reg

   // resolved mode and the enables that follow from it
   task chk_mode(input logic s, input logic f, input logic sv);
      chk("speed100", speed100, s);
      chk("full_duplex", full_duplex, f);
      chk("pwr_en_100", pwr_en_100, s | !sv);
      chk("pwr_en_10", pwr_en_10, !s | !sv);
      chk("pcs100_en", pcs100_en, s);
      chk("loopback_en", loopback_en, !s & !f);
      chk("sqe_test_en", sqe_test_en, !s & !f);
   endtask : chk_mode

   // carrier and collision under receive, transmit and overlap
   task chk_act(input logic f);
      rx_active <= 1;
      settle;
      chk("crs", crs, 1'b1);
      rx_active <= 0;
      start <= 1;
      @(posedge aclk);
      start <= 0;
      settle;
      chk("crs", crs, !f);
      chk("col", col, 1'b0);
      rx_active <= 1;
      settle;
      chk("col", col, !f);
      rx_active <= 0;
      repeat (24) @(posedge aclk);
   endtask : chk_act

   task t_modes;
      logic s, f, sv;
      for (int i = 0; i < 8; i++) begin
         s = i[0];
         f = i[1];
         sv = i[2];
         wr(`OFS_PWR_SAVE, {30'h0, sv, sv});
         wr(`OFS_CTRL, {18'h0, s, 4'h0, f, 8'h00});
         settle;
         chk_mode(s, f, sv);
         chk_act(f);
      end
   endtask : t_modes

   task t_negotiate;
      // save bits are still set from the last pass of t_modes
      wr(`OFS_CTRL, 32'h00001000);
      an_done <= 1;
      partner_ability <= 4'hf;
      settle;
      chk_mode(1'b1, 1'b1, 1'b1);
      partner_ability <= 4'h4;
      settle;
      chk_mode(1'b1, 1'b0, 1'b1);
      partner_ability <= 4'h2;
      settle;
      chk_mode(1'b0, 1'b1, 1'b1);
      cfg <= 0;
      spd_pin <= 1;
      dup_pin <= 1;
      settle;
      chk_mode(1'b1, 1'b1, 1'b1);
      an_pin <= 1;
      settle;
      chk_mode(1'b0, 1'b1, 1'b1);
   endtask : t_negotiate

   task t_regs;
      rd_reg(`OFS_ABILITY);
      chk("ability", rd[3:0], 4'hf);
      rd_reg(8'h10);
      chk("rresp", resp, `RESP_DECERR);
      wr(8'h10, 32'h0);
      chk("bresp", resp, `RESP_DECERR);
   endtask : t_regs

   initial begin
      repeat (5) @(posedge aclk);
      // reset values while reset is still held
      chk("speed100", speed100, 1'b0);
      chk("pwr_en_100", pwr_en_100, 1'b1);
      chk("pwr_en_10", pwr_en_10, 1'b1);
      chk("loopback_en", loopback_en, 1'b0);
      aresetn <= 1;
      settle;
      // control reset values seed 100M full duplex before negotiation
      chk_mode(1'b1, 1'b1, 1'b0);
      t_regs;
      t_modes;
      t_negotiate;
      test_done;
   end
endmodule : phy_mode_power_duplex_control_bench
